// *** hw/scbcr_device.sv ***
`timescale 1ns/1ns
`default_nettype none
// Function
// - Answer only bus address 1101101, bit8 direction
// - Block write: index, count, data, all acknowledged
// - Acknowledge address and index of read setup
// - Host repeats start, read address gets ack
// - Read sends count then bytes from index
// - Host acknowledges count and all but last
// - Host ends read with nack then stop
// - Byte0 gates force outputs low, reset one
// - Byte1 top bits: latched strap, read only
// - Byte1 bit5 picks strap or software mode
// - Software mode bits inert unless bit5 set
// - Byte1 low bits pick amplitude, reset 10
// - Byte2 edge rates per output, reset one
// - Byte3 bit0 feedback edge rate, reset one
// - Frequency code inert unless enable bit set
// - Byte4 always reads all ones
// - Byte5 fixed revision and maker fields
// - Byte6 fixed family and part fields
// - Byte7 low bits set read length, reset 8
// - Bus works only while reference clock runs
// - Reset frequency setting is 100 MHz
module scbcr_device
  import scbcr_pkg::*;
#(
  parameter logic [3:0] REV_ID = 4'h3,   // Arbitrary value
  parameter logic [3:0] MAKER_ID = 4'h5, // Arbitrary value
  parameter logic [1:0] FAMILY = 2'b10,  // Arbitrary value
  parameter logic [5:0] PART_ID = 6'h15  // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  scbcr_smbus_if.device bus,
  input wire logic i_ref_clk_running,
  input wire logic [1:0] i_loop_mode_strap_pin,
  input wire logic i_output1_gate_pin_n,
  input wire logic i_output0_gate_pin_n,
  output logic o_clock_output1_run,
  output logic o_clock_output0_run,
  output scbcr_pkg::scbcr_loop_mode_t o_loop_mode,
  output logic [1:0] o_amplitude,
  output logic o_output1_edge_rate,
  output logic o_output0_edge_rate,
  output logic o_feedback_edge_rate,
  output scbcr_pkg::scbcr_freq_t o_freq_code
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RX = 3'b001, ST_ACK = 3'b010, ST_TX = 3'b011, ST_RACK = 3'b100
  } scbcr_dev_state_t;
  typedef enum logic [2:0] {
    SG_ADDR = 3'b000, SG_INDEX = 3'b001, SG_COUNT = 3'b010, SG_WDATA = 3'b011,
    SG_RCOUNT = 3'b100, SG_RDATA = 3'b101
  } scbcr_dev_stage_t;
  typedef struct packed {
    scbcr_dev_state_t state;
    scbcr_dev_stage_t stage;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic tx_next;
    logic acked;
    logic [7:0] ptr;
    logic [7:0] remain;
    logic scl_prev;
    logic sda_prev;
    logic sda_oe_n;
    logic strap_done;
    logic [1:0] strap_wait;
    logic [1:0] strap;
    logic gate1;
    logic gate0;
    logic swsel;
    logic [1:0] mode;
    logic [1:0] amp;
    logic edge1;
    logic edge0;
    logic fb_edge;
    logic fen;
    logic [1:0] fsel;
    logic [4:0] len;
    logic run1;
    logic run0;
    scbcr_loop_mode_t loop_mode;
    scbcr_freq_t freq;
  } scbcr_dev_st_t;

  scbcr_dev_st_t q, d;
  logic [5:0] pins_s;
  logic scl_s, sda_s, run_s, oe1_n_s, oe0_n_s;
  logic [1:0] strap_s;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  // ==========================================================
  // Register read view with reserved bits at their defaults
  function automatic logic [7:0] reg_rd(input scbcr_dev_st_t s, input logic [7:0] a);
    logic [7:0] v;
    v = RSV_NONE;
    if (a == OFS_GATE) begin
      v = RSV_GATE;
      v[B0_OUT1] = s.gate1;
      v[B0_OUT0] = s.gate0;
    end else if (a == OFS_MODE) begin
      v = RSV_MODE;
      v[B1_STRAP_LSB +: 2] = s.strap;
      v[B1_SWSEL] = s.swsel;
      v[B1_MODE_LSB +: 2] = s.mode;
      v[B1_AMP_LSB +: 2] = s.amp;
    end else if (a == OFS_EDGE) begin
      v = RSV_EDGE;
      v[B2_OUT1] = s.edge1;
      v[B2_OUT0] = s.edge0;
    end else if (a == OFS_FREQ) begin
      v = RSV_FREQ;
      v[B3_FEN] = s.fen;
      v[B3_FSEL_LSB +: 2] = s.fsel;
      v[B3_FB] = s.fb_edge;
    end else if (a == OFS_RSVD) begin
      v = RSV_BYTE;
    end else if (a == OFS_REV) begin
      v = {REV_ID, MAKER_ID};
    end else if (a == OFS_PART) begin
      v = {FAMILY, PART_ID};
    end else if (a == OFS_LEN) begin
      v = {3'b000, s.len};
    end
    return v;
  endfunction

  // ==========================================================
  // Pin synchronisers
  scbcr_sync #(.W(6)) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({bus.scl, bus.sda, i_ref_clk_running, i_output1_gate_pin_n,
              i_output0_gate_pin_n, 1'b0}),
    .o_sync(pins_s)
  );
  scbcr_sync #(.W(2)) u_sync_strap (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_loop_mode_strap_pin),
    .o_sync(strap_s)
  );
  assign {scl_s, sda_s, run_s, oe1_n_s, oe0_n_s} = pins_s[5:1];

  // Bus edge and condition detection
  assign scl_rise = scl_s & ~q.scl_prev;
  assign scl_fall = ~scl_s & q.scl_prev;
  assign start_seen = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
  assign stop_seen = scl_s & q.scl_prev & ~q.sda_prev & sda_s;

  // ==========================================================
  // Next state: protocol engine, register writes, output controls
  always_comb begin
    d = q;
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;
    // Strap caught once, only after the synchroniser holds the real pin level
    if (!q.strap_done) begin
      d.strap_wait = q.strap_wait + 2'b01;
      if (q.strap_wait == STRAP_WAIT) begin
        d.strap = strap_s;
        d.strap_done = 1'b1;
      end
    end
    d.run1 = q.gate1 & ~oe1_n_s;
    d.run0 = q.gate0 & ~oe0_n_s;
    d.loop_mode = scbcr_loop_mode_t'(q.swsel ? q.mode : q.strap);
    d.freq = q.fen ? scbcr_freq_t'(q.fsel) : FQ_100;
    if (!run_s || stop_seen) begin
      d.state = ST_IDLE;
      d.sda_oe_n = 1'b1;
    end else if (start_seen) begin
      d.state = ST_RX;
      d.stage = SG_ADDR;
      d.bitcnt = 4'h0;
      d.sda_oe_n = 1'b1;
    end else begin
      case (q.state)
        ST_RX: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], sda_s};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == 4'h8) begin
            d.state = ST_ACK;
            d.sda_oe_n = 1'b0;
            d.tx_next = 1'b0;
            case (q.stage)
              SG_ADDR: begin
                if (q.shift[7:1] != DEV_ADDR) begin
                  d.state = ST_IDLE;
                  d.sda_oe_n = 1'b1;
                end else if (q.shift[0]) begin
                  d.tx_next = 1'b1;
                  d.stage = SG_RCOUNT;
                end else begin
                  d.stage = SG_INDEX;
                end
              end
              SG_INDEX: begin
                d.ptr = q.shift;
                d.stage = SG_COUNT;
              end
              SG_COUNT: begin
                d.remain = q.shift;
                d.stage = SG_WDATA;
              end
              default: begin
                if (q.remain != 8'h00) begin
                  d.remain = q.remain - 8'h01;
                  d.ptr = q.ptr + 8'h01;
                  if (q.ptr == OFS_GATE) begin
                    d.gate1 = q.shift[B0_OUT1];
                    d.gate0 = q.shift[B0_OUT0];
                  end else if (q.ptr == OFS_MODE) begin
                    d.swsel = q.shift[B1_SWSEL];
                    d.mode = q.shift[B1_MODE_LSB +: 2];
                    d.amp = q.shift[B1_AMP_LSB +: 2];
                  end else if (q.ptr == OFS_EDGE) begin
                    d.edge1 = q.shift[B2_OUT1];
                    d.edge0 = q.shift[B2_OUT0];
                  end else if (q.ptr == OFS_FREQ) begin
                    d.fen = q.shift[B3_FEN];
                    d.fsel = q.shift[B3_FSEL_LSB +: 2];
                    d.fb_edge = q.shift[B3_FB];
                  end else if (q.ptr == OFS_LEN) begin
                    d.len = q.shift[4:0];
                  end
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            d.bitcnt = 4'h0;
            d.sda_oe_n = 1'b1;
            d.state = ST_RX;
            if (q.tx_next) begin
              d.state = ST_TX;
              d.shift = {3'b000, q.len};
              d.sda_oe_n = d.shift[7];
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (q.bitcnt == 4'h7) begin
              d.state = ST_RACK;
              d.sda_oe_n = 1'b1;
            end else begin
              d.shift = {q.shift[6:0], 1'b0};
              d.sda_oe_n = q.shift[6];
              d.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            d.acked = ~sda_s;
          end else if (scl_fall) begin
            if (q.acked) begin
              d.state = ST_TX;
              d.stage = SG_RDATA;
              d.bitcnt = 4'h0;
              d.shift = reg_rd(q, q.ptr);
              d.sda_oe_n = d.shift[7];
              d.ptr = q.ptr + 8'h01;
            end else begin
              d.state = ST_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.stage <= SG_ADDR;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.gate1 <= RST_GATE;
      q.gate0 <= RST_GATE;
      q.swsel <= RST_SWSEL;
      q.mode <= RST_MODE;
      q.amp <= RST_AMP;
      q.edge1 <= RST_EDGE;
      q.edge0 <= RST_EDGE;
      q.fb_edge <= RST_EDGE;
      q.fen <= RST_FEN;
      q.fsel <= RST_FSEL;
      q.len <= RST_LEN;
      q.loop_mode <= LM_LOW_BW;
      q.freq <= FQ_100;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = q.sda_oe_n;
  assign o_clock_output1_run = q.run1;
  assign o_clock_output0_run = q.run0;
  assign o_loop_mode = q.loop_mode;
  assign o_amplitude = q.amp;
  assign o_output1_edge_rate = q.edge1;
  assign o_output0_edge_rate = q.edge0;
  assign o_feedback_edge_rate = q.fb_edge;
  assign o_freq_code = q.freq;
endmodule // scbcr_device
`default_nettype wire

// *** hw/scbcr_pkg.sv ***
`default_nettype none
package scbcr_pkg;
  // ==========================================================
  // Bus address and register offsets
  localparam logic [6:0] DEV_ADDR = 7'h6d;
  localparam logic [7:0] OFS_GATE = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h01;
  localparam logic [7:0] OFS_EDGE = 8'h02;
  localparam logic [7:0] OFS_FREQ = 8'h03;
  localparam logic [7:0] OFS_RSVD = 8'h04;
  localparam logic [7:0] OFS_REV = 8'h05;
  localparam logic [7:0] OFS_PART = 8'h06;
  localparam logic [7:0] OFS_LEN = 8'h07;
  // ==========================================================
  // Field positions
  localparam int B0_OUT1 = 5;
  localparam int B0_OUT0 = 3;
  localparam int B1_STRAP_LSB = 6;
  localparam int B1_SWSEL = 5;
  localparam int B1_MODE_LSB = 3;
  localparam int B1_AMP_LSB = 0;
  localparam int B2_OUT1 = 5;
  localparam int B2_OUT0 = 3;
  localparam int B3_FEN = 5;
  localparam int B3_FSEL_LSB = 3;
  localparam int B3_FB = 0;
  // ==========================================================
  // Reset values and fixed reserved bits per byte
  localparam logic RST_GATE = 1'b1;
  localparam logic RST_SWSEL = 1'b0;
  localparam logic [1:0] RST_MODE = 2'b00;
  localparam logic [1:0] RST_AMP = 2'b10;
  localparam logic RST_EDGE = 1'b1;
  localparam logic RST_FEN = 1'b0;
  localparam logic [1:0] RST_FSEL = 2'b00;
  localparam logic [4:0] RST_LEN = 5'h08;
  localparam logic [1:0] STRAP_WAIT = 2'b10; // Edges until the strap sync holds the pin
  localparam logic [7:0] RSV_GATE = 8'h07;
  localparam logic [7:0] RSV_MODE = 8'h04;
  localparam logic [7:0] RSV_EDGE = 8'h45;
  localparam logic [7:0] RSV_FREQ = 8'h46;
  localparam logic [7:0] RSV_BYTE = 8'hff;
  localparam logic [7:0] RSV_NONE = 8'h00;
  // ==========================================================
  // Mode and frequency codes
  typedef enum logic [1:0] {
    LM_LOW_BW = 2'b00, LM_BYPASS = 2'b01, LM_UNUSED = 2'b10, LM_HIGH_BW = 2'b11
  } scbcr_loop_mode_t;
  typedef enum logic [1:0] {
    FQ_100 = 2'b00, FQ_50 = 2'b01, FQ_125 = 2'b10, FQ_RSVD = 2'b11
  } scbcr_freq_t;
  // ==========================================================
  // Host timing: quarter of a 625 kHz bus clock, kept short so runs stay brief
  localparam int CLK_MHZ = 125;
  localparam int SCL_QUARTER_NS = 400;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS * CLK_MHZ + 999) / 1000;
  localparam logic [9:0] QTR_LAST = 10'(SCL_QUARTER_CYC - 1);
  // ==========================================================
  // Host command port map
  localparam logic [5:0] HOFS_CMD = 6'h00;
  localparam logic [5:0] HOFS_IDX = 6'h01;
  localparam logic [5:0] HOFS_CNT = 6'h02;
  localparam logic [5:0] HOFS_RXCNT = 6'h03;
  localparam logic [5:0] HOFS_BUF = 6'h20;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ = 1;
  localparam int STS_BUSY = 0;
  localparam int STS_NACK = 1;
endpackage
`default_nettype wire

// *** hw/scbcr_smbus_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface scbcr_smbus_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // Wired-and bus levels with pull-ups
  assign scl = ~(~host_scl_oe_n & ~host_scl_o);
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
  modport host (output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, input scl, sda);
  modport device (output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface
`default_nettype wire

// *** hw/scbcr_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module scbcr_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } scbcr_sync_st_t;
  scbcr_sync_st_t q, d;

  // Two stages; first stage feeds only the second
  always_comb begin
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;
endmodule // scbcr_sync
`default_nettype wire

// *** hw/scbcr_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module scbcr_host
  import scbcr_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  scbcr_smbus_if.host bus,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_COND = 3'b001, H_STOP = 3'b010, H_WBYTE = 3'b011, H_RBYTE = 3'b100
  } scbcr_host_state_t;
  typedef enum logic [2:0] {
    S_AW = 3'b000, S_IDX = 3'b001, S_CNT = 3'b010, S_WD = 3'b011,
    S_AR = 3'b100, S_RC = 3'b101, S_RD = 3'b110
  } scbcr_host_step_t;
  typedef struct packed {
    scbcr_host_state_t state;
    scbcr_host_step_t step;
    logic rd_op;
    logic [9:0] tick;
    logic [1:0] ph;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic ackd;
    logic [7:0] idx;
    logic [7:0] cnt;
    logic [7:0] n;
    logic scl_oe_n;
    logic sda_oe_n;
    logic nack_err;
    logic [7:0] rx_count;
    logic [7:0] rdata;
    logic [DEPTH-1:0][7:0] mem;
  } scbcr_host_st_t;

  scbcr_host_st_t q, d;
  logic sda_s;
  logic qend;

  // SDA line synchroniser
  scbcr_sync #(.W(1)) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(bus.sda),
    .o_sync(sda_s)
  );
  assign qend = (q.tick == QTR_LAST);

  // ==========================================================
  // Next state: command port, conditions, bytes and acks
  always_comb begin
    d = q;
    d.rdata = 8'h00;
    if (i_rd) begin
      if (i_addr == HOFS_CMD) begin
        d.rdata = {6'h00, q.nack_err, q.state != H_IDLE};
      end else if (i_addr == HOFS_IDX) begin
        d.rdata = q.idx;
      end else if (i_addr == HOFS_CNT) begin
        d.rdata = q.cnt;
      end else if (i_addr == HOFS_RXCNT) begin
        d.rdata = q.rx_count;
      end else if (i_addr >= HOFS_BUF) begin
        d.rdata = q.mem[i_addr[4:0]];
      end
    end
    if (i_wr && q.state == H_IDLE) begin
      if (i_addr == HOFS_CMD && (i_wdata[CMD_WRITE] || i_wdata[CMD_READ])) begin
        d.state = H_COND;
        d.step = S_AW;
        d.rd_op = i_wdata[CMD_READ];
        d.nack_err = 1'b0;
        d.tick = 10'h000;
        d.ph = 2'b00;
      end else if (i_addr == HOFS_IDX) begin
        d.idx = i_wdata;
      end else if (i_addr == HOFS_CNT) begin
        d.cnt = i_wdata;
      end else if (i_addr >= HOFS_BUF) begin
        d.mem[i_addr[4:0]] = i_wdata;
      end
    end
    if (q.state != H_IDLE) begin
      d.tick = qend ? 10'h000 : q.tick + 10'h001;
      if (qend) begin
        d.ph = q.ph + 2'b01;
        case (q.state)
          H_COND: begin
            case (q.ph)
              2'b00: d.sda_oe_n = 1'b1;
              2'b01: d.scl_oe_n = 1'b1;
              2'b10: d.sda_oe_n = 1'b0;
              default: begin
                d.scl_oe_n = 1'b0;
                d.state = H_WBYTE;
                d.bitcnt = 4'h0;
                d.shift = {DEV_ADDR, q.step == S_AR};
              end
            endcase
          end
          H_STOP: begin
            case (q.ph)
              2'b00: d.sda_oe_n = 1'b0;
              2'b01: d.scl_oe_n = 1'b1;
              2'b10: d.sda_oe_n = 1'b1;
              default: d.state = H_IDLE;
            endcase
          end
          default: begin
            case (q.ph)
              2'b00: begin
                if (q.state == H_WBYTE) begin
                  d.sda_oe_n = (q.bitcnt == 4'h8) | q.shift[7];
                end else begin
                  d.sda_oe_n = (q.bitcnt == 4'h8) ? ~q.ackd : 1'b1;
                end
              end
              2'b01: d.scl_oe_n = 1'b1;
              2'b10: begin
                if (q.bitcnt == 4'h8) begin
                  if (q.state == H_WBYTE) begin
                    d.ackd = ~sda_s;
                  end
                end else if (q.state == H_RBYTE) begin
                  d.shift = {q.shift[6:0], sda_s};
                end
              end
              default: begin
                d.scl_oe_n = 1'b0;
                d.bitcnt = q.bitcnt + 4'h1;
                if (q.state == H_WBYTE && q.bitcnt != 4'h8) begin
                  d.shift = {q.shift[6:0], 1'b0};
                end
                if (q.state == H_RBYTE && q.bitcnt == 4'h7) begin
                  if (q.step == S_RC) begin
                    d.rx_count = q.shift;
                    d.ackd = q.cnt != 8'h00;
                  end else begin
                    d.mem[q.n[4:0]] = q.shift;
                    d.ackd = (q.n + 8'h01) != q.cnt;
                  end
                end
                if (q.bitcnt == 4'h8) begin
                  d.bitcnt = 4'h0;
                  d.state = H_WBYTE;
                  if (q.state == H_RBYTE) begin
                    d.state = q.ackd ? H_RBYTE : H_STOP;
                    d.n = (q.step == S_RC) ? 8'h00 : q.n + 8'h01;
                    d.step = S_RD;
                  end else if (!q.ackd) begin
                    d.nack_err = 1'b1;
                    d.state = H_STOP;
                  end else if (q.step == S_AW) begin
                    d.step = S_IDX;
                    d.shift = q.idx;
                  end else if (q.step == S_IDX && q.rd_op) begin
                    d.step = S_AR;
                    d.state = H_COND;
                  end else if (q.step == S_IDX) begin
                    d.step = S_CNT;
                    d.shift = q.cnt;
                  end else if (q.step == S_AR) begin
                    d.step = S_RC;
                    d.state = H_RBYTE;
                  end else if (q.step == S_CNT && q.cnt != 8'h00) begin
                    d.step = S_WD;
                    d.n = 8'h00;
                    d.shift = q.mem[0];
                  end else if (q.step == S_WD && (q.n + 8'h01) != q.cnt) begin
                    d.n = q.n + 8'h01;
                    d.shift = q.mem[d.n[4:0]];
                  end else begin
                    d.state = H_STOP;
                  end
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
      q.state <= H_IDLE;
      q.step <= S_AW;
      q.scl_oe_n <= 1'b1;
      q.sda_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe_n = q.scl_oe_n;
  assign bus.host_sda_oe_n = q.sda_oe_n;
  assign o_rdata = q.rdata;
endmodule // scbcr_host
`default_nettype wire

// *** hw/scbcr_device_fix.sv ***
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** tb/scbcr_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module scbcr_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ref_clk_running,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_host_scl_oe_n,
  input wire logic i_host_sda_oe_n,
  input wire logic i_dev_sda_oe_n
);
  // ========
  // Wire checks
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_start;
    i_scl && $past(i_scl) && $fell(i_sda);
  endsequence
  sequence s_stop;
    i_scl && $past(i_scl) && $rose(i_sda);
  endsequence
  property p_start;
    s_start |-> i_dev_sda_oe_n && !i_host_sda_oe_n;
  endproperty
  a_start: assert property (p_start) else $error("start not made by host");
  property p_stop;
    s_stop |-> i_dev_sda_oe_n;
  endproperty
  a_stop: assert property (p_stop) else $error("device holds data at stop");
  property p_off;
    !i_ref_clk_running [*4] |-> i_dev_sda_oe_n;
  endproperty
  a_off: assert property (p_off) else $error("device drives without ref clock");
  property p_free;
    s_stop |=> (i_host_scl_oe_n && i_dev_sda_oe_n) [*8];
  endproperty
  a_free: assert property (p_free) else $error("bus not left free after stop");
  property p_low;
    $fell(i_scl) |=> !i_scl [*8];
  endproperty
  a_low: assert property (p_low) else $error("bus clock low too short");
  property p_high;
    $rose(i_scl) |=> i_scl [*8];
  endproperty
  a_high: assert property (p_high) else $error("bus clock high too short");
  property p_launch;
    $fell(i_dev_sda_oe_n) |=> !i_scl [*2];
  endproperty
  a_launch: assert property (p_launch) else $error("device pull too late");
  property p_hold;
    i_scl && $past(i_scl) |-> $stable(i_dev_sda_oe_n);
  endproperty
  a_hold: assert property (p_hold) else $error("device data moved in clock high");
endmodule // scbcr_chk
`default_nettype wire

// *** tb/tb_smbus_clock_buffer_config_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_smbus_clock_buffer_config_regs;
  import scbcr_pkg::*;
  logic i_clk, i_reset_n, ref_run, h_wr, h_rd, run1, run0, edge1, edge0, fb_edge;
  logic pin1_n, pin0_n;
  logic [5:0] h_addr;
  logic [7:0] h_wdata, h_rdata, s;
  logic [1:0] amp;
  scbcr_loop_mode_t mode;
  scbcr_freq_t freq;
  int n_mismatch, checks;
  scbcr_smbus_if bus ();
  scbcr_device scbcr_device_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus),
    .i_ref_clk_running(ref_run), .i_loop_mode_strap_pin(2'b11),
    .i_output1_gate_pin_n(pin1_n), .i_output0_gate_pin_n(pin0_n),
    .o_clock_output1_run(run1), .o_clock_output0_run(run0), .o_loop_mode(mode),
    .o_amplitude(amp), .o_output1_edge_rate(edge1), .o_output0_edge_rate(edge0),
    .o_feedback_edge_rate(fb_edge), .o_freq_code(freq));
  scbcr_host scbcr_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(bus),
    .i_addr(h_addr), .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata));
  scbcr_chk scbcr_chk_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_ref_clk_running(ref_run), .i_scl(bus.scl), .i_sda(bus.sda),
    .i_host_scl_oe_n(bus.host_scl_oe_n), .i_host_sda_oe_n(bus.host_sda_oe_n),
    .i_dev_sda_oe_n(bus.dev_sda_oe_n));
  // ========
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ========
  // Tasks
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] v);
    checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, e, v);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge i_clk);
    h_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge i_clk);
    h_rd <= 1'b0;
    #1;
    d = h_rdata;
    @(posedge i_clk);
  endtask
  // Start a bus transfer and poll busy under a bound
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] n, input logic [7:0] x);
    logic [7:0] st;
    wr(HOFS_CNT, x);
    wr(HOFS_IDX, n);
    wr(HOFS_CMD, cmd);
    for (int i = 0; i < 20000; i++) begin
      rd(HOFS_CMD, st);
      if (st[STS_BUSY] === 1'b0) break;
      if (i == 19999) begin
        n_mismatch++;
        conclude();
      end
    end
  endtask
  task automatic wblk(input logic [7:0] n, input logic [7:0] d [$]);
    foreach (d[k]) wr(HOFS_BUF + 6'(k), d[k]);
    xfer(8'h01, n, 8'(d.size()));
  endtask
  task automatic rblk(input logic [7:0] n, input logic [7:0] e [$]);
    logic [7:0] v;
    xfer(8'h02, n, 8'(e.size()));
    rd(HOFS_RXCNT, v);
    chk("count", 8'(e.size()), v);
    foreach (e[k]) begin
      rd(HOFS_BUF + 6'(k), v);
      chk("byte", e[k], v);
    end
  endtask
  task automatic outs(input logic [7:0] e1, input logic [7:0] e2);
    chk("outputs", e1, {run1, run0, amp, edge1, edge0, fb_edge, 1'b0});
    chk("modes", e2, {4'h0, mode, freq});
  endtask
  // ========
  // Main sequence
  initial begin
    n_mismatch = 0;
    checks = 0;
    i_reset_n = 1'b0;
    ref_run = 1'b1;
    pin1_n = 1'b0;
    pin0_n = 1'b0;
    h_wr = 1'b0;
    h_rd = 1'b0;
    h_addr = 6'h00;
    h_wdata = 8'h00;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (10) @(posedge i_clk);
    outs(8'hee, 8'h0c);
    pin1_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    outs(8'h6e, 8'h0c);
    pin1_n <= 1'b0;
    pin0_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    outs(8'hae, 8'h0c);
    pin0_n <= 1'b0;
    wblk(8'h03, '{8'h18, 8'h00, 8'h00, 8'h00, 8'he2});
    outs(8'hec, 8'h0c);
    rblk(8'h04, '{8'hff, 8'h35});
    rblk(8'h06, '{8'h95, 8'h02});
    wblk(8'h00, '{8'h00, 8'h2d, 8'h00, 8'h30});
    outs(8'h10, 8'h06);
    rblk(8'h00, '{8'h07, 8'hed});
    rblk(8'h02, '{8'h45, 8'h76});
    rd(HOFS_CMD, s);
    chk("status", 8'h00, s);
    ref_run <= 1'b0;
    repeat (8) @(posedge i_clk);
    wblk(8'h00, '{8'h28});
    rd(HOFS_CMD, s);
    chk("status", 8'h02, s);
    outs(8'h10, 8'h06);
    conclude();
  end
endmodule // tb_smbus_clock_buffer_config_regs
`default_nettype wire
